// ==== pkg/drc_pkg.sv ====
// Shared constants and carriers for the strobed dynamic RAM controller
package drc_pkg;

  // Clock period in picoseconds (200 MHz)
  localparam int unsigned CLK_PERIOD_PS = 5000;

  // Array geometry
  localparam int unsigned ADDR_W    = 12;     // Cell address width
  localparam int unsigned ROW_W     = 6;      // Refresh row address width
  localparam int unsigned ROW_COUNT = 64;     // Rows to visit per interval
  localparam int unsigned WORDS     = 4096;   // Words in the array

  // Documented times, figures as printed
  localparam int unsigned T_REF_MS       = 2;    // Refresh interval, standard grade
  localparam int unsigned T_REF_SLOW_MS  = 1;    // Refresh interval, slowest grade
  localparam int unsigned T_AH_NS        = 150;  // Address hold time
  localparam int unsigned T_CF_NS        = 130;  // Output release time
  localparam int unsigned T_RWC_NS       = 650;  // Combined cycle time, standard
  localparam int unsigned T_RWC_SLOW_NS  = 960;  // Combined cycle time, slowest
  localparam int unsigned T_CE_NS        = 300;  // Strobe high time, read/write
  localparam int unsigned T_CC_NS        = 130;  // Strobe low time
  localparam int unsigned T_CO_NS        = 280;  // Strobe to output delay
  localparam int unsigned T_CRW_NS       = 480;  // Strobe width in combined cycle
  localparam int unsigned T_WP_NS        = 180;  // Write strobe pulse width

  // Cycle counts; minima round up
  localparam int unsigned AH_CYC   = (T_AH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CE_CYC   = (T_CE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CC_CYC   = (T_CC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CF_CYC   = (T_CF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CO_CYC   = (T_CO_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CRW_CYC  = (T_CRW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WP_CYC   = (T_WP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RWC_CYC  = (T_RWC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Refresh interval split over all rows; a longest time rounds down
  localparam int unsigned REF_CYC  = (T_REF_MS * 1000000000 / CLK_PERIOD_PS);
  localparam int unsigned ROW_GAP_CYC = REF_CYC / ROW_COUNT;

  // Timer width wide enough for every count
  localparam int unsigned TMR_W = 16;

  // Values after reset
  localparam logic [ROW_W-1:0] ROW_RESET = 6'h00;

  // Host request carrier
  typedef struct packed {
    logic              wr;     // 1 write, 0 read
    logic              read_modify_write_cycle;    // Combined read then write
    logic [ADDR_W-1:0] addr;   // Cell address
    logic              wdata;  // Bit to write
  } drc_req_s;

  // Pins toward the memory
  typedef struct packed {
    logic              strobe;    // Cycle strobe, active high
    logic              sel_n;     // Unit select, active low
    logic              wen_n;     // Write strobe, active low
    logic [ADDR_W-1:0] addr;      // Cell address lines
    logic              din;       // Data input to the memory
  } drc_pins_s;

endpackage : drc_pkg

// ==== rtl/drc_ref_timer.sv ====
`timescale 1ns/1ps
// Refresh interval timer and row pointer
module drc_ref_timer
  import drc_pkg::*;
#(
  parameter int unsigned ROW_GAP = ROW_GAP_CYC  // Cycles between row refreshes
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic             done,      // Row refresh finished
  output logic                  due,       // A row is owed a refresh
  output logic [ROW_W-1:0]      row        // Next row to refresh
);

  logic [TMR_W-1:0] tick;  // Counts toward the next row slot

  // Raise a request once per slot; the slot sets over a same-cycle done
  always_ff @(posedge clock) begin
    if (srst) begin
      tick <= '0;
      due  <= 1'b0;
    end else begin
      if (tick == TMR_W'(ROW_GAP - 1)) begin
        tick <= '0;
        due  <= 1'b1;
      end else begin
        tick <= tick + TMR_W'(1);
        if (done) begin
          due <= 1'b0;
        end
      end
    end
  end

  // Walk all rows in turn
  always_ff @(posedge clock) begin
    if (srst) begin
      row <= ROW_RESET;
    end else if (done) begin
      row <= row + ROW_W'(1);
    end
  end

endmodule // drc_ref_timer

// ==== rtl/drc_ctrl.sv ====
`timescale 1ns/1ps
module drc_ctrl
  import drc_pkg::*;
(
  input  wire logic     clock,
  input  wire logic     srst,
  input  wire drc_req_s req,        // Host request
  input  wire logic     req_valid,  // Request offered
  output logic          req_ready,  // Request taken this cycle
  output logic          rsp_valid,  // Read data valid, one cycle
  output logic          rsp_data,   // Read bit, true polarity
  output drc_pins_s     pins,       // Drive toward the memory
  input  wire logic     dout_pin,   // Memory data output pin
  output logic          busy        // Cycle in progress
);

  typedef enum {ST_IDLE, ST_HIGH, ST_WLOW, ST_LOW} drc_state_e;

  drc_state_e       state;       // Cycle phase
  logic [TMR_W-1:0] cnt;         // Phase timer
  logic             is_ref;      // Current cycle is a refresh
  logic             is_rmw;      // Current cycle is combined
  logic             is_wr;       // Current cycle is a plain write
  logic             dout_s1;     // Synchroniser first stage
  logic             dout_s2;     // Synchronised data output
  logic             ref_due;     // Timer asks for a refresh
  logic             ref_done;    // Refresh cycle ends
  logic [ROW_W-1:0] ref_row;     // Row to refresh
  logic [TMR_W-1:0] high_cyc;    // Strobe high length for this cycle

  // Row pacing; 64 slots per interval keep every row inside the limit
  drc_ref_timer u_ref (
    .clock (clock),
    .srst  (srst),
    .done  (ref_done),
    .due   (ref_due),
    .row   (ref_row)
  );

  // Two flops before the pin is read
  always_ff @(posedge clock) begin
    if (srst) begin
      dout_s1 <= 1'b0;
      dout_s2 <= 1'b0;
    end else begin
      dout_s1 <= dout_pin;
      dout_s2 <= dout_s1;
    end
  end

  // Combined cycles keep the strobe up longer
  always_comb begin
    high_cyc = is_rmw ? TMR_W'(CRW_CYC) : TMR_W'(CE_CYC);
  end

  assign ref_done = (state == ST_LOW) && (cnt == '0) && is_ref;

  // Cycle sequencer; refresh takes priority over host work
  always_ff @(posedge clock) begin
    if (srst) begin
      state  <= ST_IDLE;
      cnt    <= '0;
      is_ref <= 1'b0;
      is_rmw <= 1'b0;
      is_wr  <= 1'b0;
      pins   <= '{strobe: 1'b0, sel_n: 1'b1, wen_n: 1'b1, addr: '0, din: 1'b0};
      req_ready <= 1'b0;
    end else begin
      req_ready <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (ref_due) begin
            // Read at the row; select left high
            is_ref       <= 1'b1;
            is_rmw       <= 1'b0;
            is_wr        <= 1'b0;
            pins.addr    <= {{(ADDR_W-ROW_W){1'b0}}, ref_row};
            pins.sel_n   <= 1'b1;
            pins.wen_n   <= 1'b1;
            pins.strobe  <= 1'b1;
            // Full width: the strobe falls CE_CYC + 1 edges after the rise
            cnt          <= TMR_W'(CE_CYC);
            state        <= ST_HIGH;
          end else if (req_valid && !req_ready) begin
            is_ref       <= 1'b0;
            is_rmw       <= req.read_modify_write_cycle;
            is_wr        <= req.wr && !req.read_modify_write_cycle;
            pins.addr    <= req.addr;
            pins.sel_n   <= 1'b0;
            // Early write: data and write strobe set with the rise
            pins.wen_n   <= !(req.wr && !req.read_modify_write_cycle);
            pins.din     <= req.wdata;
            pins.strobe  <= 1'b1;
            req_ready    <= 1'b1;
            // No minus one here, so the strobe stays up one cycle past its minimum
            cnt          <= req.read_modify_write_cycle ? TMR_W'(CRW_CYC) : TMR_W'(CE_CYC);
            state        <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          // Hold address well beyond the hold time while high
          if (is_rmw && cnt == high_cyc - TMR_W'(CO_CYC + 2)) begin
            pins.wen_n <= 1'b0;  // Data now valid, write back
          end
          if (cnt == '0) begin
            pins.strobe <= 1'b0;
            pins.wen_n  <= 1'b1;
            // Low time covers precharge, release and the combined spacing
            cnt   <= TMR_W'(CF_CYC + RWC_CYC - CRW_CYC - 1);
            state <= ST_LOW;
          end else begin
            cnt <= cnt - TMR_W'(1);
          end
        end
        ST_LOW: begin
          pins.sel_n <= 1'b1;
          if (cnt == '0) begin
            state <= ST_IDLE;
          end else begin
            cnt <= cnt - TMR_W'(1);
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Capture the read bit near the strobe fall; the pin reads inverted
  always_ff @(posedge clock) begin
    if (srst) begin
      rsp_valid <= 1'b0;
      rsp_data  <= 1'b0;
    end else begin
      rsp_valid <= (state == ST_HIGH) && (cnt == '0) && !is_ref && !is_wr;
      rsp_data  <= !dout_s2;
    end
  end

  // Busy mirrors any cycle in flight
  always_ff @(posedge clock) begin
    if (srst) begin
      busy <= 1'b0;
    end else begin
      busy <= (state != ST_IDLE) || ref_due;
    end
  end

  // Write strobe may fall only once the strobe has been high the output delay;
  // the low phase outlasts that delay, so an early fall sees a low strobe here
  a_rmw_wen_hold: assert property (@(posedge clock) disable iff (srst)
    $fell(pins.wen_n) && is_rmw |-> $past(pins.strobe, CO_CYC))
    else $error("write strobe fell before output was valid");

  // Select is low with the strobe on host cycles
  a_sel_on_rise: assert property (@(posedge clock) disable iff (srst)
    $rose(pins.strobe) && !is_ref |-> !pins.sel_n)
    else $error("select not low at strobe rise");

  // Address holds steady while strobe is high
  a_addr_hold: assert property (@(posedge clock) disable iff (srst)
    pins.strobe && $past(pins.strobe) |-> $stable(pins.addr))
    else $error("address moved during strobe high");

  // Refresh address lies in the low six bits
  a_ref_row: assert property (@(posedge clock) disable iff (srst)
    $rose(pins.strobe) && is_ref |-> pins.addr[ADDR_W-1:ROW_W] == '0 && pins.wen_n)
    else $error("refresh address out of row range");

  // Strobe stays low at least 8 cycles after a fall
  a_low_gap: assert property (@(posedge clock) disable iff (srst)
    $fell(pins.strobe) |-> !pins.strobe [*8])
    else $error("strobe rose too soon after fall");

  // Early write: write strobe low at the rise, data set with it and then held
  a_early_wr: assert property (@(posedge clock) disable iff (srst)
    $rose(pins.strobe) && is_wr |-> !pins.wen_n ##1 $stable(pins.din))
    else $error("write data not set at strobe rise");

  // Read responses come only from read and combined cycles, never from plain writes or refresh
  a_rsp_src: assert property (@(posedge clock) disable iff (srst)
    rsp_valid |-> !$past(is_wr) && !$past(is_ref) && !pins.strobe)
    else $error("read data from a write cycle");

  // Refresh is served within a slot once owed
  a_ref_serve: assert property (@(posedge clock) disable iff (srst)
    $rose(ref_due) |-> ##[1:400] (state == ST_HIGH && is_ref))
    else $error("refresh not started in time");

endmodule // drc_ctrl

// ==== sim/drc_mem_model.sv ====
`timescale 1ns/1ps
// Behavioural memory on the far side, with checks on the controller's timing
module drc_mem_model
  import drc_pkg::*;
(
  input  wire drc_pins_s pins,     // Pins from the controller
  input  wire logic      slow,     // Late answer near the end of the high phase
  output logic           dout_pin, // Data out, inverted
  output int             viol,     // Timing faults seen on the pins
  output int             n_ref     // Deselected refresh cycles
);
  logic              mem [WORDS];    // One bit per word
  logic [ADDR_W-1:0] a;              // Latched cell address
  logic              sel;            // Latched select
  logic              rd;             // Read mode at the rise
  logic              wrote;          // A write seen in this cycle
  logic              wd;             // Bit to store
  logic              up;             // Strobe seen high
  logic              last_rmw;       // Previous cycle was combined
  logic [ROW_W-1:0]  last_row;       // Last refreshed row
  realtime           t_rise;         // Time of the last rise
  realtime           t_fall;         // Time of the last fall
  realtime           t_row [ROW_COUNT]; // Time each row was last visited
  initial begin
    foreach (mem[i]) mem[i] = 1'b0;
    foreach (t_row[i]) t_row[i] = 0.0;
    {viol, n_ref} = '0;
    {dout_pin, up, last_rmw, wrote, sel, rd} = '0;
    last_row = '1;
    t_rise = -1.0e4;
    t_fall = -1.0e4;
  end
  // Edge tracking; a change is only acted on at the fall or while the strobe is high
  always @(pins) begin
    if (pins.strobe && !up) begin
      if ($realtime - t_fall < T_CC_NS) viol++;
      if (last_rmw && $realtime - t_rise < T_RWC_NS) viol++;
      t_rise = $realtime;
      a = pins.addr;
      sel = !pins.sel_n;
      rd = pins.wen_n;
      wrote = 1'b0;
      up = 1'b1;
      if (!sel) begin
        n_ref++;
        if (pins.addr[ROW_W-1:0] !== last_row + 1'b1) viol++;
        last_row = pins.addr[ROW_W-1:0];
      end
      // Every visit refreshes the row, selected or not
      if (t_row[a[ROW_W-1:0]] > 0.0 && $realtime - t_row[a[ROW_W-1:0]] > T_REF_MS * 1.0e6) viol++;
      t_row[a[ROW_W-1:0]] = $realtime;
    end else if (!pins.strobe && up) begin
      // Strobe high width: combined cycles need the longer one
      if ($realtime - t_rise < ((rd && wrote) ? T_CRW_NS : T_CE_NS)) viol++;
      if (wrote) mem[a] = wd;
      last_rmw = rd && wrote;
      t_fall = $realtime;
      up = 1'b0;
    end else if (up && $realtime - t_rise < T_AH_NS && pins.addr !== a) begin
      viol++;
    end
    // Data input is only heard when selected and in write mode
    if (up && sel && !pins.wen_n) begin
      if (rd && $realtime - t_rise < T_CO_NS) viol++;
      wrote = 1'b1;
      wd = pins.din;
    end
  end
  // Read data appears 60 ns after the rise, or after the output delay when slow, inverted
  always @(posedge pins.strobe) begin
    #(slow ? T_CO_NS : 60);
    if (pins.strobe && sel && rd) dout_pin = ~mem[a];
  end
  // Floating output: inverse of the last value, so a stale read cannot pass
  always @(negedge pins.strobe) begin
    #20;
    if (!pins.strobe) dout_pin = ~dout_pin;
  end
endmodule // drc_mem_model

// ==== sim/drc_ctrl_tb.sv ====
`timescale 1ns/1ps
// Self-checking bench: random accesses against a reference array
module drc_ctrl_tb;
  import drc_pkg::*;
  logic      clock, srst, req_valid, req_ready, rsp_valid, rsp_data, dout_pin, busy, slow;
  drc_req_s  req;        // Request toward the controller
  drc_pins_s pins;       // Memory pins
  int        viol, n_ref, bad_count, n_compared, cycles, lo;
  int        ref_mem [WORDS]; // Reference contents, true polarity
  logic [ADDR_W-1:0] ad;
  drc_ctrl dut_u (.clock(clock), .srst(srst), .req(req), .req_valid(req_valid), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins), .dout_pin(dout_pin), .busy(busy));
  drc_mem_model mem_u (.pins(pins), .slow(slow), .dout_pin(dout_pin), .viol(viol), .n_ref(n_ref));
  // Free-running 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Hang guard, well above the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic check_bit(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic check_int(input int got, input int lo, input int hi, input string what);
    n_compared++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("wrong value at %0t: %s %0d", $time, what, got);
    end
  endtask
  // One access; waits are bounded since a refresh may hold the request back
  task automatic access(input logic wr, input logic read_modify_write_cycle, input logic [ADDR_W-1:0] ad, input logic wd);
    int   n;
    logic exp;
    exp = (ref_mem[ad] != 0);
    @(posedge clock);
    req <= '{wr: wr, read_modify_write_cycle: read_modify_write_cycle, addr: ad, wdata: wd};
    req_valid <= 1'b1;
    n = 0;
    do begin @(negedge clock); n++; end while (req_ready !== 1'b1 && n < 400);
    check_bit(req_ready, 1'b1, "request not taken");
    @(posedge clock);
    req_valid <= 1'b0;
    @(negedge clock);
    check_bit(busy, 1'b1, "busy during cycle");
    if (wr || read_modify_write_cycle) ref_mem[ad] = int'(wd);
    if (!wr) begin
      n = 0;
      do begin @(negedge clock); n++; end while (rsp_valid !== 1'b1 && n < 200);
      check_bit(rsp_valid, 1'b1, "read answer missing");
      check_bit(rsp_data, exp, "read bit");
    end
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    {srst, req_valid, slow} = 3'b100;
    req = '0;
    {bad_count, n_compared, cycles} = '0;
    foreach (ref_mem[i]) ref_mem[i] = 0;
    void'($urandom(32'h2981AEFE));
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    @(negedge clock);
    check_bit(pins.strobe, 1'b0, "strobe after reset");
    check_bit(pins.sel_n, 1'b1, "select after reset");
    check_bit(pins.wen_n, 1'b1, "write strobe after reset");
    check_bit(busy, 1'b0, "busy after reset");
    check_bit(rsp_valid, 1'b0, "answer after reset");
    access(1'b1, 1'b0, '1, 1'b1);
    access(1'b0, 1'b0, '1, 1'b0);
    access(1'b0, 1'b0, '1, 1'b0);
    access(1'b0, 1'b1, '1, 1'b0);
    access(1'b0, 1'b1, '1, 1'b1);
    // Random mix over the two end words and random words, prompt and slow answers
    repeat (80) begin
      case ($urandom_range(2))
        0: ad = '0;
        1: ad = '1;
        default: ad = ADDR_W'($urandom);
      endcase
      slow <= 1'($urandom);
      case ($urandom_range(2))
        0: access(1'b0, 1'b0, ad, 1'b0);
        1: access(1'b1, 1'b0, ad, 1'($urandom));
        default: access(1'b0, 1'b1, ad, 1'($urandom));
      endcase
    end
    // Idle spell: refresh keeps visiting rows in order
    repeat (14000) @(posedge clock);
    lo = (cycles - 12) / int'(ROW_GAP_CYC);
    check_int(n_ref, lo - 1, lo + 1, "refresh count");
    check_int(viol, 0, 0, "pin timing faults");
    print_verdict();
  end
endmodule // drc_ctrl_tb
